// *** logic/spsc_top.sv ***
/*
 * spsc_top: apb slave holding the shift control, line output, line input and
 * shift status registers, plus per-channel clock debounce, strong rise drive,
 * weak pull-up control and a minimal shift mode sequencer.
 * assumes: pclk 50 mhz, line inputs synchronous to pclk, pads resolve oe/out.
 */
//
// Overview of operation
// - reset clears shift control register to zero
// - enable low keeps shifter idle, software drives lines
// - enable high runs shifter on enabled channels
// - transmit select bit picks receive or transmit
// - strong drive after rise for coded clocks
// - clock input accepted after coded stable count
// - weak pull-up on when bit set, not driving low
// - all channel enables clear resets shifter, status
`timescale 1ns/1ps
`default_nettype none
module spsc_top
	import spsc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  clk_line_in,
	input  wire logic [3:0]  dat_line_in,
	output logic      [3:0]  clk_line_out,
	output logic      [3:0]  clk_line_oe,
	output logic      [3:0]  dat_line_out,
	output logic      [3:0]  dat_line_oe,
	output logic      [3:0]  clk_pullup_on,
	output logic      [3:0]  dat_pullup_on,
	output logic      [3:0]  clk_stable
);

	logic [7:0]  shift_control_reg, shift_control_next;
	logic [7:0]  line_output_reg, line_output_next;
	logic [7:0]  status_reg, status_next;
	logic [31:0] prdata_reg, prdata_next;
	logic        pready_reg, pready_next;
	logic        pslverr_reg, pslverr_next;
	spsc_state_t state_reg, state_next;

	logic       access, wr, hit, any_ch;
	logic [5:0] deb_len;
	logic [1:0] rise_len;
	logic [7:0] line_input;
	logic [3:0] ch_en, dat_ctl;

	assign access = psel & penable & ~pready_reg;
	assign wr     = access & pwrite;
	assign hit    = paddr == SPSC_OFF_SHIFT_CONTROL || paddr == SPSC_OFF_LINE_OUTPUT
		|| paddr == SPSC_OFF_LINE_INPUT || paddr == SPSC_OFF_SHIFT_STATUS;

	// decode debounce length; codes 5,6,7 saturate at 32
	always_comb begin
		unique case (shift_control_reg[SPSC_DEB_LO +: 3])
			3'h0: deb_len = 6'h01;
			3'h1: deb_len = 6'h02;
			3'h2: deb_len = 6'h04;
			3'h3: deb_len = 6'h08;
			3'h4: deb_len = 6'h10;
			default: deb_len = SPSC_DEB_MAX;
		endcase
		// code 3 acts as two clocks
		rise_len = (shift_control_reg[SPSC_RISE_LO +: 2] == 2'h3) ? SPSC_RISE_MAX
			: shift_control_reg[SPSC_RISE_LO +: 2];
	end

	// strong high drive of one or two clocks, then released
	sequence s_drive_one(oe);
		oe ##1 !oe;
	endsequence
	sequence s_drive_two(oe);
		oe ##1 oe ##1 !oe;
	endsequence

	// per-channel line logic
	logic [5:0] deb_cnt_reg  [SPSC_NCH];
	logic [5:0] deb_cnt_next [SPSC_NCH];
	logic [1:0] crise_reg [SPSC_NCH], crise_next [SPSC_NCH];
	logic [1:0] drise_reg [SPSC_NCH], drise_next [SPSC_NCH];
	logic [3:0] stable_reg, stable_next;
	logic [3:0] cval_reg, dval_reg, cval_next, dval_next;
	logic [3:0] c_oe_reg, c_oe_next, d_oe_reg, d_oe_next;
	logic [3:0] c_pu_reg, c_pu_next, d_pu_reg, d_pu_next;

	genvar g;
	generate
		for (g = 0; g < SPSC_NCH; g++) begin : g_ch
			assign ch_en[g]   = line_output_reg[SPSC_CLK_POS[g]];
			assign dat_ctl[g] = line_output_reg[SPSC_DAT_POS[g]];
			assign line_input[SPSC_CLK_POS[g]] = clk_line_in[g];
			assign line_input[SPSC_DAT_POS[g]] = dat_line_in[g];

			always_comb begin
				deb_cnt_next[g] = deb_cnt_reg[g];
				stable_next[g]  = stable_reg[g];
				// new level only after deb_len equal samples
				if (clk_line_in[g] == stable_reg[g]) begin
					deb_cnt_next[g] = 6'h00;
				end else if (deb_cnt_reg[g] + 6'h01 >= deb_len) begin
					stable_next[g]  = clk_line_in[g];
					deb_cnt_next[g] = 6'h00;
				end else begin
					deb_cnt_next[g] = deb_cnt_reg[g] + 6'h01;
				end
				// clock line low when channel disabled, else released
				cval_next[g] = ch_en[g];
				dval_next[g] = dat_ctl[g];
				// strong high drive after low to high transition
				crise_next[g] = (ch_en[g] & ~cval_reg[g]) ? rise_len
					: (crise_reg[g] != 2'h0 ? crise_reg[g] - 2'h1 : 2'h0);
				drise_next[g] = (dat_ctl[g] & ~dval_reg[g]) ? rise_len
					: (drise_reg[g] != 2'h0 ? drise_reg[g] - 2'h1 : 2'h0);
				c_oe_next[g] = ~ch_en[g] | (crise_next[g] != 2'h0);
				d_oe_next[g] = ~dat_ctl[g] | (drise_next[g] != 2'h0);
				c_pu_next[g] = shift_control_reg[SPSC_BIT_PULLUP] & ch_en[g];
				d_pu_next[g] = shift_control_reg[SPSC_BIT_PULLUP] & dat_ctl[g];
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					deb_cnt_reg[g] <= 6'h00;
					crise_reg[g]   <= 2'h0;
					drise_reg[g]   <= 2'h0;
				end else begin
					deb_cnt_reg[g] <= deb_cnt_next[g];
					crise_reg[g]   <= crise_next[g];
					drise_reg[g]   <= drise_next[g];
				end
			end

			a_rise_len: assert property (@(posedge pclk) disable iff (!presetn)
				$rose(cval_reg[g]) && $past(rise_len) == 2'h2 && rise_len == 2'h2
				|-> s_drive_two(c_oe_reg[g]))
				else $error("strong rise drive length wrong");
			a_rise_one: assert property (@(posedge pclk) disable iff (!presetn)
				$rose(cval_reg[g]) && $past(rise_len) == 2'h1 && rise_len == 2'h1
				|-> s_drive_one(c_oe_reg[g]))
				else $error("one clock rise drive wrong");
			a_rise_none: assert property (@(posedge pclk) disable iff (!presetn)
				$rose(cval_reg[g]) && $past(rise_len) == 2'h0 |-> !c_oe_reg[g])
				else $error("strong drive while disabled");
			a_rise_sat: assert property (@(posedge pclk) disable iff (!presetn)
				$rose(cval_reg[g]) && $past(shift_control_reg[SPSC_RISE_LO +: 2]) == 2'h3
				&& shift_control_reg[SPSC_RISE_LO +: 2] == 2'h3 |-> s_drive_two(c_oe_reg[g]))
				else $error("rise code three not two clocks");
			a_data_rise: assert property (@(posedge pclk) disable iff (!presetn)
				$rose(dval_reg[g]) && $past(rise_len) == 2'h2 && rise_len == 2'h2
				|-> s_drive_two(d_oe_reg[g]))
				else $error("data rise drive length wrong");
			a_deb_one: assert property (@(posedge pclk) disable iff (!presetn)
				deb_len == 6'h01 && clk_line_in[g] != stable_reg[g]
				|=> stable_reg[g] == $past(clk_line_in[g]))
				else $error("single cycle debounce not taken");
			a_clk_forced: assert property (@(posedge pclk) disable iff (!presetn)
				!ch_en[g] |=> c_oe_reg[g] && !cval_reg[g])
				else $error("disabled channel clock not low");
			a_data_forced: assert property (@(posedge pclk) disable iff (!presetn)
				!dat_ctl[g] |=> d_oe_reg[g] && !dval_reg[g])
				else $error("data line not forced low");
			a_pullup_off: assert property (@(posedge pclk) disable iff (!presetn)
				!cval_reg[g] |-> !c_pu_reg[g])
				else $error("pull-up active while driving low");
			a_pullup_on: assert property (@(posedge pclk) disable iff (!presetn)
				shift_control_reg[SPSC_BIT_PULLUP] && ch_en[g] |=> c_pu_reg[g])
				else $error("pull-up missing on released clock");
			a_pullup_dis: assert property (@(posedge pclk) disable iff (!presetn)
				!shift_control_reg[SPSC_BIT_PULLUP] |=> !c_pu_reg[g] && !d_pu_reg[g])
				else $error("pull-up on while disabled");
			a_data_pu: assert property (@(posedge pclk) disable iff (!presetn)
				!dval_reg[g] |-> !d_pu_reg[g])
				else $error("data pull-up active while driving low");
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stable_reg <= 4'hF;
			cval_reg   <= 4'h0;
			dval_reg   <= 4'hF;
			c_oe_reg   <= 4'hF;
			d_oe_reg   <= 4'h0;
			c_pu_reg   <= 4'h0;
			d_pu_reg   <= 4'h0;
		end else begin
			stable_reg <= stable_next;
			cval_reg   <= cval_next;
			dval_reg   <= dval_next;
			c_oe_reg   <= c_oe_next;
			d_oe_reg   <= d_oe_next;
			c_pu_reg   <= c_pu_next;
			d_pu_reg   <= d_pu_next;
		end
	end

	assign any_ch = |ch_en;

	// registers, apb answer and shift mode sequencer
	always_comb begin
		shift_control_next = shift_control_reg;
		line_output_next   = line_output_reg;
		status_next        = status_reg;
		state_next         = state_reg;
		prdata_next        = 32'h0000_0000;
		pready_next        = access;
		pslverr_next       = access & ~hit;
		if (wr && paddr == SPSC_OFF_SHIFT_CONTROL)
			shift_control_next = pwdata[7:0];
		if (wr && paddr == SPSC_OFF_LINE_OUTPUT)
			line_output_next = pwdata[7:0];
		if (access && !pwrite) begin
			unique case (1'b1)
				paddr == SPSC_OFF_SHIFT_CONTROL: prdata_next = {24'h0, shift_control_reg};
				paddr == SPSC_OFF_LINE_OUTPUT:   prdata_next = {24'h0, line_output_reg};
				paddr == SPSC_OFF_LINE_INPUT:    prdata_next = {24'h0, line_input};
				paddr == SPSC_OFF_SHIFT_STATUS:  prdata_next = {24'h0, status_reg};
				default:                         prdata_next = 32'h0000_0000;
			endcase
		end
		if (!shift_control_reg[SPSC_BIT_ENABLE]) begin
			state_next = SPSC_IDLE;
		end else if (!any_ch) begin
			state_next  = SPSC_IDLE;
			status_next = 8'h00;
		end else begin
			state_next = shift_control_reg[SPSC_BIT_TRANSMIT] ? SPSC_TX : SPSC_RX;
			status_next = {5'h00, 1'b0, 1'b0, ~|(stable_reg & ch_en)};
		end
		if (!shift_control_reg[SPSC_BIT_ENABLE])
			status_next = 8'h00;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_control_reg <= SPSC_CTRL_RESET;
			line_output_reg   <= SPSC_LOUT_RESET;
			status_reg        <= 8'h00;
			state_reg         <= SPSC_IDLE;
			prdata_reg        <= 32'h0000_0000;
			pready_reg        <= 1'b0;
			pslverr_reg       <= 1'b0;
		end else begin
			shift_control_reg <= shift_control_next;
			line_output_reg   <= line_output_next;
			status_reg        <= status_next;
			state_reg         <= state_next;
			prdata_reg        <= prdata_next;
			pready_reg        <= pready_next;
			pslverr_reg       <= pslverr_next;
		end
	end

	assign prdata        = prdata_reg;
	assign pready        = pready_reg;
	assign pslverr       = pslverr_reg;
	assign clk_line_out  = cval_reg;
	assign clk_line_oe   = c_oe_reg;
	assign dat_line_out  = dval_reg;
	assign dat_line_oe   = d_oe_reg;
	assign clk_pullup_on = c_pu_reg;
	assign dat_pullup_on = d_pu_reg;
	assign clk_stable    = stable_reg;

	a_reset_clear: assert property (@(posedge pclk)
		$rose(presetn) |-> shift_control_reg == 8'h00)
		else $error("control not cleared by reset");
	a_idle_disabled: assert property (@(posedge pclk) disable iff (!presetn)
		!shift_control_reg[SPSC_BIT_ENABLE] |=> state_reg == SPSC_IDLE)
		else $error("shifter active while disabled");
	a_run_enabled: assert property (@(posedge pclk) disable iff (!presetn)
		shift_control_reg[SPSC_BIT_ENABLE] && any_ch && $stable(shift_control_reg)
		|=> state_reg != SPSC_IDLE)
		else $error("shifter idle while enabled");
	a_direction: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SPSC_TX |-> $past(shift_control_reg[SPSC_BIT_TRANSMIT]))
		else $error("direction does not follow select");
	a_chan_reset: assert property (@(posedge pclk) disable iff (!presetn)
		!any_ch |=> state_reg == SPSC_IDLE && status_reg == 8'h00)
		else $error("shifter not reset with channels off");
	a_deb_sat: assert property (@(posedge pclk) disable iff (!presetn)
		shift_control_reg[6:5] == 2'b11 |-> deb_len == 6'h20)
		else $error("debounce code not saturated");
	a_deb_hold: assert property (@(posedge pclk) disable iff (!presetn)
		deb_len == 6'h04 && $stable(deb_len) && clk_line_in[0] != stable_reg[0]
		&& deb_cnt_reg[0] == 6'h00 |=> stable_reg[0] == $past(stable_reg[0]))
		else $error("clock level taken before debounce");
	a_apb_resp: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready_reg |=> pready_reg ##1 !pready_reg)
		else $error("apb answer not one cycle");
	a_status_off: assert property (@(posedge pclk) disable iff (!presetn)
		!shift_control_reg[SPSC_BIT_ENABLE] |=> status_reg == 8'h00)
		else $error("status kept while shifter disabled");
	a_rx_direction: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SPSC_RX |-> !$past(shift_control_reg[SPSC_BIT_TRANSMIT]))
		else $error("receive without select cleared");
	a_apb_err: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready_reg && !hit |=> pslverr_reg)
		else $error("unmapped access without error");

endmodule
`default_nettype wire

// *** inc/spsc_pkg.sv ***
/*
 * spsc_pkg: register map, field positions, reset values and counts for the
 * serial port shift control block.
 * assumes: included before the design file; no other dependencies.
 */
`default_nettype none
package spsc_pkg;
	localparam logic [15:0] SPSC_OFF_SHIFT_CONTROL = 16'hFE84;
	localparam logic [15:0] SPSC_OFF_LINE_OUTPUT   = 16'hFE86;
	localparam logic [15:0] SPSC_OFF_LINE_INPUT    = 16'hFE88;
	localparam logic [15:0] SPSC_OFF_SHIFT_STATUS  = 16'hFE8C;

	localparam logic [7:0] SPSC_CTRL_RESET = 8'h00;
	localparam logic [7:0] SPSC_LOUT_RESET = 8'h47;

	localparam int SPSC_BIT_ENABLE   = 0;
	localparam int SPSC_BIT_TRANSMIT = 1;
	localparam int SPSC_RISE_LO      = 2;
	localparam int SPSC_DEB_LO       = 4;
	localparam int SPSC_BIT_PULLUP   = 7;

	localparam int SPSC_NCH = 4;
	// channel enable and data bit positions in the line output register
	localparam int SPSC_CLK_POS [SPSC_NCH] = '{3, 4, 5, 7};
	localparam int SPSC_DAT_POS [SPSC_NCH] = '{0, 1, 2, 6};

	localparam logic [5:0] SPSC_DEB_MAX  = 6'h20;
	localparam logic [1:0] SPSC_RISE_MAX = 2'h2;

	typedef enum logic [2:0] {
		SPSC_IDLE = 3'b001,
		SPSC_RX   = 3'b010,
		SPSC_TX   = 3'b100
	} spsc_state_t;
endpackage
`default_nettype wire

// *** verif/spsc_line_dev.sv ***
/*
 * spsc_line_dev: far-side keyboard or pointing device on the open-drain lines.
 * assumes: design enables, pull-up enables and device pull-downs settle each pad.
 */
`timescale 1ns/1ps
`default_nettype none
module spsc_line_dev (
	input  wire logic       pclk,
	input  wire logic [3:0] clk_out,
	input  wire logic [3:0] clk_oe,
	input  wire logic [3:0] dat_out,
	input  wire logic [3:0] dat_oe,
	input  wire logic [3:0] clk_pu,
	input  wire logic [3:0] dat_pu,
	input  wire logic [3:0] dev_clk_low,
	input  wire logic [3:0] dev_dat_low,
	output logic      [3:0] clk_line,
	output logic      [3:0] dat_line
);
	logic flip = 1'b0;
	// a floating line changes every cycle
	always_ff @(posedge pclk) begin
		flip <= ~flip;
	end
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			clk_line[i] = clk_oe[i] ? clk_out[i] : dev_clk_low[i] ? 1'b0 : clk_pu[i] ? 1'b1 : flip;
			dat_line[i] = dat_oe[i] ? dat_out[i] : dev_dat_low[i] ? 1'b0 : dat_pu[i] ? 1'b1 : flip;
		end
	end
endmodule
`default_nettype wire

// *** verif/spsc_top_tb_top.sv ***
/*
 * spsc_top_tb_top: apb-driven register and line tests of the shift control block.
 * assumes: spsc_pkg compiled first; spsc_line_dev models the far side.
 */
`timescale 1ns/1ps
`default_nettype none
module spsc_top_tb_top import spsc_pkg::*; ();
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic [3:0]  clk_in, dat_in, clk_out, clk_oe, dat_out, dat_oe, clk_pu, dat_pu;
	logic [3:0]  clk_stable, dev_clk_low, dev_dat_low;
	int          error_cnt, total_checks, cnt, d0;

	spsc_top spsc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .clk_line_in(clk_in), .dat_line_in(dat_in), .clk_line_out(clk_out),
		.clk_line_oe(clk_oe), .dat_line_out(dat_out), .dat_line_oe(dat_oe),
		.clk_pullup_on(clk_pu), .dat_pullup_on(dat_pu), .clk_stable(clk_stable));
	spsc_line_dev spsc_line_dev_i (.pclk(pclk), .clk_out(clk_out), .clk_oe(clk_oe),
		.dat_out(dat_out), .dat_oe(dat_oe), .clk_pu(clk_pu), .dat_pu(dat_pu),
		.dev_clk_low(dev_clk_low), .dev_dat_low(dev_dat_low), .clk_line(clk_in), .dat_line(dat_in));

	task automatic final_report();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(negedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdata = prdata;
		rerr = pslverr;
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		chk(32'(n < 20), 32'h1);
	endtask
	task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdata, exp);
	endtask
	task automatic rise_run(input logic [1:0] code, output int c);
		apb(1'b1, SPSC_OFF_SHIFT_CONTROL, {28'h0, code, 2'h0});
		apb(1'b1, SPSC_OFF_LINE_OUTPUT, 32'h00);
		repeat (4) @(posedge pclk);
		apb(1'b1, SPSC_OFF_LINE_OUTPUT, 32'hFF);
		c = 0;
		repeat (8) begin
			@(negedge pclk);
			c += int'((clk_oe & clk_out) === 4'hF);
		end
	endtask
	task automatic deb_run(input logic [2:0] code, output int c);
		apb(1'b1, SPSC_OFF_SHIFT_CONTROL, {24'h0, 1'b1, code, 4'h0});
		repeat (40) @(posedge pclk);
		dev_clk_low <= 4'h1;
		c = 0;
		while (clk_stable[0] !== 1'b0 && c < 100) begin
			@(negedge pclk);
			c++;
		end
		@(posedge pclk);
		dev_clk_low <= 4'h0;
		repeat (40) @(posedge pclk);
	endtask

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		final_report();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0;
		pwdata = 32'h0;
		dev_clk_low = 4'h0;
		dev_dat_low = 4'h0;
		error_cnt = 0;
		total_checks = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		chk({24'h0, clk_oe, clk_out}, 32'hF0);
		chk({24'h0, clk_pu, dat_pu}, 32'h0);
		rchk(SPSC_OFF_SHIFT_CONTROL, 32'h0);
		rchk(SPSC_OFF_LINE_OUTPUT, {24'h0, SPSC_LOUT_RESET});
		apb(1'b0, 16'hFE90, 32'h0);
		chk({rerr, rdata[30:0]}, 32'h80000000);
		for (int k = 0; k < SPSC_NCH; k++) begin
			apb(1'b1, SPSC_OFF_SHIFT_CONTROL, 32'h5A >> k | 32'h81);
			rchk(SPSC_OFF_SHIFT_CONTROL, 32'h5A >> k | 32'h81);
		end
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rchk(SPSC_OFF_SHIFT_CONTROL, 32'h0);
		rchk(SPSC_OFF_LINE_OUTPUT, {24'h0, SPSC_LOUT_RESET});
		apb(1'b1, SPSC_OFF_SHIFT_CONTROL, 32'h01);
		apb(1'b1, SPSC_OFF_LINE_OUTPUT, 32'h08);
		dev_clk_low <= 4'h1;
		repeat (4) @(posedge pclk);
		rchk(SPSC_OFF_SHIFT_STATUS, 32'h1);
		apb(1'b1, SPSC_OFF_LINE_OUTPUT, 32'h47);
		rchk(SPSC_OFF_SHIFT_STATUS, 32'h0);
		apb(1'b1, SPSC_OFF_SHIFT_CONTROL, 32'h03);
		apb(1'b1, SPSC_OFF_LINE_OUTPUT, 32'h08);
		repeat (4) @(posedge pclk);
		rchk(SPSC_OFF_SHIFT_STATUS, 32'h1);
		apb(1'b1, SPSC_OFF_SHIFT_CONTROL, 32'h00);
		rchk(SPSC_OFF_SHIFT_STATUS, 32'h0);
		dev_clk_low <= 4'h0;
		apb(1'b1, SPSC_OFF_SHIFT_CONTROL, 32'h80);
		apb(1'b1, SPSC_OFF_LINE_OUTPUT, 32'hFE);
		dev_dat_low <= 4'h2;
		repeat (6) @(posedge pclk);
		chk({24'h0, dat_oe, dat_out}, 32'h1E);
		chk({28'h0, dat_pu}, 32'hE);
		chk({28'h0, clk_pu}, 32'hF);
		rchk(SPSC_OFF_LINE_INPUT, 32'hFC);
		dev_dat_low <= 4'h0;
		apb(1'b1, SPSC_OFF_SHIFT_CONTROL, 32'h00);
		repeat (3) @(posedge pclk);
		chk({28'h0, dat_pu}, 32'h0);
		for (int k = 0; k < 4; k++) begin
			rise_run(2'(k), cnt);
			chk(32'(cnt), 32'(k < 2 ? k : 2));
		end
		for (int k = 0; k < 8; k++) begin
			deb_run(3'(k), cnt);
			d0 = (k == 0) ? cnt : d0;
			chk(32'(cnt - d0), 32'((k > 5 ? 32 : 1 << k) - 1));
		end
		final_report();
	end
endmodule
`default_nettype wire
